// *** src/sdh_pkg.sv ***
// Package with the register maps and field layouts used by the card controller.
package sdh_pkg;

  // ******************************************************************
  // Own register map, reached over the APB slave port.
  // ******************************************************************
  localparam logic [7:0] OWN_CTRL   = 8'h00;
  localparam logic [7:0] OWN_CFG    = 8'h04;
  localparam logic [7:0] OWN_BLK    = 8'h08;
  localparam logic [7:0] OWN_ARG    = 8'h0c;
  localparam logic [7:0] OWN_CMD    = 8'h10;
  localparam logic [7:0] OWN_STAT   = 8'h14;
  localparam logic [7:0] OWN_DATA   = 8'h18;
  localparam logic [7:0] OWN_WCNT   = 8'h1c;
  localparam logic [7:0] OWN_LASTSR = 8'h20;

  // Operations started through the control register, bits 3:1.
  localparam logic [2:0] OP_BOOT    = 3'h1;
  localparam logic [2:0] OP_SDIO    = 3'h2;
  localparam logic [2:0] OP_CMD     = 3'h3;
  localparam logic [2:0] OP_RECOVER = 3'h4;
  localparam logic [2:0] OP_ABORT   = 3'h5;

  // Configuration register fields.
  localparam int CFG_SLOT_LSB  = 0;
  localparam int CFG_WIDTH_LSB = 2;
  localparam int CFG_TRANSFER_TYPE_FIELD_LSB = 4;
  localparam int CFG_IOSP_LSB  = 8;
  localparam int CFG_INIT_DONE = 10;
  localparam int CFG_DMA_EN    = 11;
  localparam int CFG_BOOT_ACK  = 12;
  localparam int CFG_NIEN_CLR  = 13;
  localparam int CFG_RESP61    = 14;
  localparam int CFG_IRQ_LSB   = 16;

  // Own status register bits.
  localparam int ST_BUSY  = 0;
  localparam int ST_DONE  = 1;
  localparam int ST_ERR   = 2;
  localparam int ST_PARAM = 3;
  localparam int ST_HARD  = 4;

  // ******************************************************************
  // Map of the card host interface outside.
  // ******************************************************************
  localparam logic [31:0] DEV_ARGR = 32'h0000_0010;
  localparam logic [31:0] DEV_SDCR = 32'h0000_000c;
  localparam logic [31:0] DEV_CMDR = 32'h0000_0014;
  localparam logic [31:0] DEV_BLKR = 32'h0000_0018;
  localparam logic [31:0] DEV_RDR  = 32'h0000_0030;
  localparam logic [31:0] DEV_SR   = 32'h0000_0040;
  localparam logic [31:0] DEV_IER  = 32'h0000_0044;
  localparam logic [31:0] DEV_DMA  = 32'h0000_0050;

  // Command, SDCR, block and DMA register fields of the card host interface.
  localparam int CMDR_SPECIAL_COMMAND_FIELD_LSB = 8;
  localparam int CMDR_TRANSFER_COMMAND_FIELD_LSB = 16;
  localparam int CMDR_TRANSFER_DIRECTION_FIELD     = 18;
  localparam int CMDR_TRANSFER_TYPE_FIELD_LSB = 19;
  localparam int CMDR_IOSP_LSB  = 24;
  localparam int CMDR_BOOT_ACK  = 27;
  localparam int SDCR_WIDTH_LSB = 6;
  localparam int BLKR_LEN_LSB   = 16;
  localparam logic [31:0] DMA_ENABLE = 32'h0000_0100;

  // Special command codes, transfer codes and command indices.
  localparam logic [2:0] SPC_NONE    = 3'h0;
  localparam logic [2:0] SPC_CS_DIS  = 3'h3;
  localparam logic [2:0] SPC_BOOT_REQUEST_CODE = 3'h6;
  localparam logic [2:0] SPC_BOOT_END_CODE = 3'h7;
  localparam logic [1:0] TRC_START   = 2'h1;
  localparam logic [5:0] CMD_IDLE    = 6'h00;
  localparam logic [5:0] CMD_STOP    = 6'h0c;
  localparam logic [5:0] CMD_FASTIO  = 6'h27;

  // Status register bits of the card host interface.
  localparam int SR_CMDRDY   = 0;
  localparam int SR_RECEIVE_READY_FLAG    = 1;
  localparam int SR_SDIO_LSB = 8;
  localparam int SR_CSRCV    = 13;
  localparam int SR_DMADONE  = 25;
  localparam int SR_TRANSFER_DONE_FLAG  = 27;
  localparam logic [31:0] SR_ERR_MASK = 32'h00ff_0000;

  // Legal transfer counts.
  localparam logic [15:0] SDIO_MAX_BYTES  = 16'h0200;
  localparam logic [15:0] SDIO_MAX_BLOCKS = 16'h01ff;
  localparam logic [15:0] BOOT_BLOCK_LEN  = 16'h0200;

endpackage : sdh_pkg

// *** src/sdh_ctrl.sv ***
// Controller that drives a card host interface over APB on orders from its own registers.
`timescale 1ns/1ps

// Overview of operation
// - Force one data line until init done.
// - Check SDIO byte and block count limits.
// - Transfer type set in command write.
// - IO special command set in command write.
// - CE-ATA uses CMD0, 12, 39, 60, 61.
// - Polled ATA via CMD60, poll, CMD61.
// - Wait completion signal received status.
// - Abort sends special command three.
// - Recovery: disable, CMD12, then CMD39.
// - Failed recovery issues CMD0 hard reset.
// - ATA error bit needs only retry.
// - Boot holds command line before CMD1.
// - Boot: width, 512 length, block count.
// - Boot request with read, start data.
// - Read data on receive ready, end boot.
// - DMA boot enables DMA, ends after completion.
module sdh_ctrl #(
  parameter int SLOTS = 4
) (
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave for own registers.
  input  wire logic        s_psel,
  input  wire logic        s_penable,
  input  wire logic        s_pwrite,
  input  wire logic [7:0]  s_paddr,
  input  wire logic [31:0] s_pwdata,
  output logic             s_pready,
  output logic [31:0]      s_prdata,
  output logic             s_pslverr,
  // APB master toward the card host interface.
  output logic             m_psel,
  output logic             m_penable,
  output logic             m_pwrite,
  output logic [31:0]      m_paddr,
  output logic [31:0]      m_pwdata,
  input  wire logic        m_pready,
  input  wire logic [31:0] m_prdata
);

  typedef enum logic [3:0] {
    S_IDLE = 4'h0, S_SDCR = 4'h1, S_BLKR = 4'h2, S_DMA = 4'h3,
    S_IER  = 4'h4, S_ARGR = 4'h5, S_CMDR = 4'h6, S_POLL = 4'h7,
    S_CHK  = 4'h8, S_RDR  = 4'h9, S_DAT  = 4'ha, S_END = 4'hb,
    S_BUS  = 4'hc, S_FIN  = 4'hd
  } sdh_state_t;

  function automatic logic [31:0] sdh_cmdr(input logic [5:0] idx, input logic [2:0] spc,
                                           input logic [1:0] trc, input logic dir,
                                           input logic [2:0] typ, input logic [1:0] iosp,
                                           input logic ack);
    logic [31:0] v;
    v = 32'h0000_0000;
    v[5:0] = idx;
    v[sdh_pkg::CMDR_SPECIAL_COMMAND_FIELD_LSB +: 3] = spc;
    v[sdh_pkg::CMDR_TRANSFER_COMMAND_FIELD_LSB +: 2] = trc;
    v[sdh_pkg::CMDR_TRANSFER_DIRECTION_FIELD] = dir;
    v[sdh_pkg::CMDR_TRANSFER_TYPE_FIELD_LSB +: 3] = typ;
    v[sdh_pkg::CMDR_IOSP_LSB +: 2] = iosp;
    v[sdh_pkg::CMDR_BOOT_ACK] = ack;
    return v;
  endfunction : sdh_cmdr

  // ******************************************************************
  // State.
  // ******************************************************************
  logic [31:0] cfg_reg, cfg_next, blk_reg, blk_next, arg_reg, arg_next, cmd_reg, cmd_next;
  logic [4:0]  stat_reg, stat_next;
  logic [31:0] data_reg, data_next, wcnt_reg, wcnt_next, sr_reg, sr_next;
  logic [2:0]  op_reg, op_next;
  logic [1:0]  stage_reg, stage_next;
  sdh_state_t  st_reg, st_next, ret_reg, ret_next;
  logic        sp_reg, sp_next;
  logic [31:0] sprd_reg, sprd_next;
  logic        sperr_reg, sperr_next;
  logic        mpsel_reg, mpsel_next, mpen_reg, mpen_next, mpw_reg, mpw_next;
  logic [31:0] maddr_reg, maddr_next, mwd_reg, mwd_next;

  logic        s_wr, s_rd, start, mapped;
  logic [1:0]  width_eff;
  logic [15:0] count, blen;
  logic [31:0] err_bits;
  logic [31:0] irq_en;

  assign s_wr   = s_psel && s_penable && s_pwrite && !sp_reg;
  assign s_rd   = s_psel && s_penable && !s_pwrite && !sp_reg;
  assign start  = s_wr && s_paddr == sdh_pkg::OWN_CTRL && s_pwdata[0] && !stat_reg[sdh_pkg::ST_BUSY];
  assign count  = blk_reg[15:0];
  assign blen   = blk_reg[31:16];
  assign err_bits = sr_reg & sdh_pkg::SR_ERR_MASK;
  // Until initialisation is finished the card only talks on one data line.
  assign width_eff = cfg_reg[sdh_pkg::CFG_INIT_DONE] ? cfg_reg[sdh_pkg::CFG_WIDTH_LSB +: 2] : 2'h0;

  always_comb
  begin
    irq_en = 32'h0000_0000;
    for (int i = 0; i < SLOTS; i++)
      irq_en[sdh_pkg::SR_SDIO_LSB + i] = cfg_reg[sdh_pkg::CFG_IRQ_LSB + i];
    irq_en[sdh_pkg::SR_CSRCV] = cfg_reg[sdh_pkg::CFG_NIEN_CLR];
  end

  always_comb
  begin
    case (s_paddr)
      sdh_pkg::OWN_CTRL, sdh_pkg::OWN_CFG, sdh_pkg::OWN_BLK, sdh_pkg::OWN_ARG, sdh_pkg::OWN_CMD,
      sdh_pkg::OWN_STAT, sdh_pkg::OWN_DATA, sdh_pkg::OWN_WCNT, sdh_pkg::OWN_LASTSR: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // ******************************************************************
  // APB slave: one wait cycle, then a registered answer.
  // ******************************************************************
  always_comb
  begin
    sp_next    = s_psel && s_penable && !sp_reg;
    sperr_next = s_psel && s_penable && !sp_reg && !mapped;
    sprd_next  = 32'h0000_0000;
    if (s_rd)
    begin
      unique case (s_paddr)
        sdh_pkg::OWN_CFG:    sprd_next = cfg_reg;
        sdh_pkg::OWN_BLK:    sprd_next = blk_reg;
        sdh_pkg::OWN_ARG:    sprd_next = arg_reg;
        sdh_pkg::OWN_CMD:    sprd_next = cmd_reg;
        sdh_pkg::OWN_STAT:   sprd_next = {27'h0, stat_reg};
        sdh_pkg::OWN_DATA:   sprd_next = data_reg;
        sdh_pkg::OWN_WCNT:   sprd_next = wcnt_reg;
        sdh_pkg::OWN_LASTSR: sprd_next = sr_reg;
        default:             sprd_next = 32'h0000_0000;
      endcase
    end
  end

  // ******************************************************************
  // Sequencer and APB master.
  // ******************************************************************
  always_comb
  begin
    cfg_next = cfg_reg;
    blk_next = blk_reg;
    arg_next = arg_reg;
    cmd_next = cmd_reg;
    stat_next = stat_reg;
    data_next = data_reg;
    wcnt_next = wcnt_reg;
    sr_next = sr_reg;
    op_next = op_reg;
    stage_next = stage_reg;
    st_next = st_reg;
    ret_next = ret_reg;
    mpsel_next = mpsel_reg;
    mpen_next = mpen_reg;
    mpw_next = mpw_reg;
    maddr_next = maddr_reg;
    mwd_next = mwd_reg;
    if (s_wr && !stat_reg[sdh_pkg::ST_BUSY])
    begin
      unique case (s_paddr)
        sdh_pkg::OWN_CFG: cfg_next = s_pwdata;
        sdh_pkg::OWN_BLK: blk_next = s_pwdata;
        sdh_pkg::OWN_ARG: arg_next = s_pwdata;
        sdh_pkg::OWN_CMD: cmd_next = s_pwdata;
        default: ;
      endcase
    end
    if (s_wr && s_paddr == sdh_pkg::OWN_STAT)
      stat_next[sdh_pkg::ST_HARD:sdh_pkg::ST_DONE] = stat_reg[sdh_pkg::ST_HARD:sdh_pkg::ST_DONE] & ~s_pwdata[4:1];
    unique case (st_reg)
      S_IDLE:
      begin
        if (start)
        begin
          op_next = s_pwdata[3:1];
          stage_next = 2'h0;
          wcnt_next = 32'h0000_0000;
          stat_next[sdh_pkg::ST_PARAM] = 1'b0;
          stat_next[sdh_pkg::ST_ERR] = 1'b0;
          if (s_pwdata[3:1] == sdh_pkg::OP_SDIO && (count == 16'h0000 ||
              (cfg_reg[sdh_pkg::CFG_TRANSFER_TYPE_FIELD_LSB +: 3] == 3'h0 && count > sdh_pkg::SDIO_MAX_BYTES) ||
              (cfg_reg[sdh_pkg::CFG_TRANSFER_TYPE_FIELD_LSB +: 3] != 3'h0 && count > sdh_pkg::SDIO_MAX_BLOCKS)))
            stat_next[sdh_pkg::ST_PARAM] = 1'b1;
          else
          begin
            stat_next[sdh_pkg::ST_BUSY] = 1'b1;
            if (s_pwdata[3:1] == sdh_pkg::OP_ABORT || s_pwdata[3:1] == sdh_pkg::OP_RECOVER)
              st_next = S_ARGR;
            else
              st_next = S_SDCR;
          end
        end
      end
      S_SDCR:
      begin
        mwd_next = {24'h0, width_eff, 4'h0, cfg_reg[sdh_pkg::CFG_SLOT_LSB +: 2]};
        maddr_next = sdh_pkg::DEV_SDCR;
        mpw_next = 1'b1;
        ret_next = S_BLKR;
        st_next = S_BUS;
      end
      S_BLKR:
      begin
        // Boot streams always use 512-byte blocks; byte mode ignores the length.
        if (op_reg == sdh_pkg::OP_BOOT)
          mwd_next = {sdh_pkg::BOOT_BLOCK_LEN, count};
        else
          mwd_next = {blen, count};
        maddr_next = sdh_pkg::DEV_BLKR;
        ret_next = (op_reg == sdh_pkg::OP_BOOT && cfg_reg[sdh_pkg::CFG_DMA_EN]) ? S_DMA : S_IER;
        st_next = S_BUS;
      end
      S_DMA:
      begin
        mwd_next = sdh_pkg::DMA_ENABLE;
        maddr_next = sdh_pkg::DEV_DMA;
        ret_next = S_IER;
        st_next = S_BUS;
      end
      S_IER:
      begin
        mwd_next = irq_en;
        maddr_next = sdh_pkg::DEV_IER;
        ret_next = S_ARGR;
        st_next = S_BUS;
      end
      S_ARGR:
      begin
        mwd_next = arg_reg;
        maddr_next = sdh_pkg::DEV_ARGR;
        mpw_next = 1'b1;
        ret_next = S_CMDR;
        st_next = S_BUS;
      end
      S_CMDR:
      begin
        maddr_next = sdh_pkg::DEV_CMDR;
        mpw_next = 1'b1;
        ret_next = S_POLL;
        st_next = S_BUS;
        unique case (op_reg)
          // Holding the command line low is the interface's job between these two writes.
          sdh_pkg::OP_BOOT:
            mwd_next = sdh_cmdr(6'h00, sdh_pkg::SPC_BOOT_REQUEST_CODE, sdh_pkg::TRC_START, 1'b1, 3'h0, 2'h0,
                                cfg_reg[sdh_pkg::CFG_BOOT_ACK]);
          sdh_pkg::OP_SDIO:
            mwd_next = sdh_cmdr(cmd_reg[5:0], cmd_reg[10:8], cmd_reg[17:16], cmd_reg[18],
                                cfg_reg[sdh_pkg::CFG_TRANSFER_TYPE_FIELD_LSB +: 3],
                                cfg_reg[sdh_pkg::CFG_IOSP_LSB +: 2], 1'b0);
          sdh_pkg::OP_ABORT:
            mwd_next = sdh_cmdr(6'h00, sdh_pkg::SPC_CS_DIS, 2'h0, 1'b0, 3'h0, 2'h0, 1'b0);
          sdh_pkg::OP_RECOVER:
          begin
            unique case (stage_reg)
              2'h0:
                if (cfg_reg[sdh_pkg::CFG_NIEN_CLR] && cfg_reg[sdh_pkg::CFG_RESP61])
                  mwd_next = sdh_cmdr(6'h00, sdh_pkg::SPC_CS_DIS, 2'h0, 1'b0, 3'h0, 2'h0, 1'b0);
                else
                begin
                  stage_next = 2'h1;
                  st_next = S_CMDR;
                end
              2'h1: mwd_next = sdh_cmdr(sdh_pkg::CMD_STOP, sdh_pkg::SPC_NONE, 2'h0, 1'b0, 3'h0, 2'h0, 1'b0);
              2'h2: mwd_next = sdh_cmdr(sdh_pkg::CMD_FASTIO, sdh_pkg::SPC_NONE, 2'h0, 1'b0, 3'h0, 2'h0, 1'b0);
              2'h3: mwd_next = sdh_cmdr(sdh_pkg::CMD_IDLE, sdh_pkg::SPC_NONE, 2'h0, 1'b0, 3'h0, 2'h0, 1'b0);
            endcase
          end
          // Plain commands carry CMD60 and CMD61 for CE-ATA as written by software.
          default:
            mwd_next = sdh_cmdr(cmd_reg[5:0], cmd_reg[10:8], cmd_reg[17:16], cmd_reg[18],
                                3'h0, 2'h0, 1'b0);
        endcase
      end
      S_POLL:
      begin
        maddr_next = sdh_pkg::DEV_SR;
        mpw_next = 1'b0;
        ret_next = S_CHK;
        st_next = S_BUS;
      end
      S_CHK:
      begin
        st_next = S_POLL;
        if (err_bits != 32'h0000_0000)
        begin
          // A failed recovery step falls through to the hard reset once.
          if (op_reg == sdh_pkg::OP_RECOVER && stage_reg != 2'h3)
          begin
            stage_next = 2'h3;
            st_next = S_CMDR;
          end
          else
          begin
            stat_next[sdh_pkg::ST_ERR] = 1'b1;
            st_next = (op_reg == sdh_pkg::OP_BOOT) ? S_END : S_FIN;
          end
        end
        else if (op_reg == sdh_pkg::OP_BOOT)
        begin
          if (!cfg_reg[sdh_pkg::CFG_DMA_EN] && sr_reg[sdh_pkg::SR_RECEIVE_READY_FLAG])
            st_next = S_RDR;
          else if (cfg_reg[sdh_pkg::CFG_DMA_EN] ? sr_reg[sdh_pkg::SR_DMADONE] : sr_reg[sdh_pkg::SR_TRANSFER_DONE_FLAG])
            st_next = S_END;
        end
        else if (op_reg == sdh_pkg::OP_RECOVER)
        begin
          if (sr_reg[sdh_pkg::SR_CMDRDY])
          begin
            if (stage_reg == 2'h3)
            begin
              stat_next[sdh_pkg::ST_HARD] = 1'b1;
              st_next = S_FIN;
            end
            else if (stage_reg == 2'h2)
              st_next = S_FIN;
            else
            begin
              stage_next = stage_reg + 2'h1;
              st_next = S_CMDR;
            end
          end
        end
        // An ATA error bit is inside the card's own status, so it ends here as a clean retryable finish.
        else if (cmd_reg[17:16] != 2'h0 ? sr_reg[sdh_pkg::SR_TRANSFER_DONE_FLAG]
                 : (sr_reg[sdh_pkg::SR_CMDRDY] &&
                    (!cfg_reg[sdh_pkg::CFG_NIEN_CLR] || sr_reg[sdh_pkg::SR_CSRCV] ||
                     op_reg == sdh_pkg::OP_ABORT)))
          st_next = S_FIN;
      end
      S_RDR:
      begin
        maddr_next = sdh_pkg::DEV_RDR;
        mpw_next = 1'b0;
        ret_next = S_DAT;
        st_next = S_BUS;
      end
      S_DAT:
      begin
        data_next = sr_reg;
        sr_next = 32'h0000_0000;
        wcnt_next = wcnt_reg + 32'h0000_0001;
        st_next = S_POLL;
      end
      S_END:
      begin
        mwd_next = sdh_cmdr(6'h00, sdh_pkg::SPC_BOOT_END_CODE, 2'h0, 1'b0, 3'h0, 2'h0, 1'b0);
        maddr_next = sdh_pkg::DEV_CMDR;
        mpw_next = 1'b1;
        ret_next = S_FIN;
        st_next = S_BUS;
      end
      S_BUS:
      begin
        if (!mpsel_reg)
          mpsel_next = 1'b1;
        else if (!mpen_reg)
          mpen_next = 1'b1;
        else if (m_pready)
        begin
          mpsel_next = 1'b0;
          mpen_next = 1'b0;
          if (!mpw_reg)
            sr_next = m_prdata;
          st_next = ret_reg;
        end
      end
      S_FIN:
      begin
        stat_next[sdh_pkg::ST_BUSY] = 1'b0;
        stat_next[sdh_pkg::ST_DONE] = 1'b1;
        st_next = S_IDLE;
      end
      default: st_next = S_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg_reg <= 32'h0000_0000;
      blk_reg <= 32'h0000_0000;
      arg_reg <= 32'h0000_0000;
      cmd_reg <= 32'h0000_0000;
      stat_reg <= 5'h00;
      data_reg <= 32'h0000_0000;
      wcnt_reg <= 32'h0000_0000;
      sr_reg <= 32'h0000_0000;
      op_reg <= 3'h0;
      stage_reg <= 2'h0;
      st_reg <= S_IDLE;
      ret_reg <= S_IDLE;
      sp_reg <= 1'b0;
      sprd_reg <= 32'h0000_0000;
      sperr_reg <= 1'b0;
      mpsel_reg <= 1'b0;
      mpen_reg <= 1'b0;
      mpw_reg <= 1'b0;
      maddr_reg <= 32'h0000_0000;
      mwd_reg <= 32'h0000_0000;
    end
    else
    begin
      cfg_reg <= cfg_next;
      blk_reg <= blk_next;
      arg_reg <= arg_next;
      cmd_reg <= cmd_next;
      stat_reg <= stat_next;
      data_reg <= data_next;
      wcnt_reg <= wcnt_next;
      sr_reg <= sr_next;
      op_reg <= op_next;
      stage_reg <= stage_next;
      st_reg <= st_next;
      ret_reg <= ret_next;
      sp_reg <= sp_next;
      sprd_reg <= sprd_next;
      sperr_reg <= sperr_next;
      mpsel_reg <= mpsel_next;
      mpen_reg <= mpen_next;
      mpw_reg <= mpw_next;
      maddr_reg <= maddr_next;
      mwd_reg <= mwd_next;
    end
  end

  assign s_pready  = sp_reg;
  assign s_prdata  = sprd_reg;
  assign s_pslverr = sperr_reg;
  assign m_psel    = mpsel_reg;
  assign m_penable = mpen_reg;
  assign m_pwrite  = mpw_reg;
  assign m_paddr   = maddr_reg;
  assign m_pwdata  = mwd_reg;

endmodule : sdh_ctrl

// *** sim/sdh_ctrl_properties.sv ***
// Port checker for the card controller.
`timescale 1ns/1ps
module sdh_ctrl_props (
  // Clock and reset.
  input wire logic        pclk,
  input wire logic        presetn,
  // Own register port.
  input wire logic        s_psel,
  input wire logic        s_penable,
  input wire logic [7:0]  s_paddr,
  input wire logic        s_pready,
  input wire logic [31:0] s_prdata,
  input wire logic        s_pslverr,
  // Port toward the card host interface.
  input wire logic        m_psel,
  input wire logic        m_penable,
  input wire logic [31:0] m_paddr,
  input wire logic [31:0] m_pwdata,
  input wire logic        m_pready
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ****
  // Properties.
  // ****
  chk_one_wait: assert property (s_psel && s_penable && !$past(s_penable) |=> s_pready)
    else $error("own port answer not one wait");
  chk_ready_pulse: assert property (s_pready |=> !s_pready)
    else $error("own port ready longer than one cycle");
  chk_rdata_idle: assert property (!s_pready |-> s_prdata == 32'h0)
    else $error("read data outside answer");
  chk_err_unmapped: assert property (s_pready && s_paddr > 8'h20 |-> s_pslverr)
    else $error("unmapped access not refused");
  chk_err_mapped: assert property (s_pslverr |-> s_pready && (s_paddr > 8'h20 || s_paddr[1:0] != 2'h0))
    else $error("error on mapped access");
  chk_setup_phase: assert property ($rose(m_psel) |-> !m_penable ##1 m_penable)
    else $error("master setup phase wrong");
  chk_hold_req: assert property (m_psel && m_penable && !m_pready |=>
    m_psel && m_penable && $stable(m_paddr) && $stable(m_pwdata))
    else $error("master request not held");
  chk_master_release: assert property (m_psel && m_penable && m_pready |=> !m_psel && !m_penable)
    else $error("master request not released");
  cover property (s_pready && s_pslverr);
  cover property (m_psel && m_penable && !m_pready ##1 m_pready);
  cover property (s_pready && s_paddr == 8'h1c);
endmodule : sdh_ctrl_props

bind sdh_ctrl sdh_ctrl_props u_props (
  .pclk(pclk), .presetn(presetn), .s_psel(s_psel), .s_penable(s_penable), .s_paddr(s_paddr),
  .s_pready(s_pready), .s_prdata(s_prdata), .s_pslverr(s_pslverr), .m_psel(m_psel),
  .m_penable(m_penable), .m_paddr(m_paddr), .m_pwdata(m_pwdata), .m_pready(m_pready));

// *** sim/sdh_card_model.sv ***
// Behavioural card host interface answering the controller.
`timescale 1ns/1ps
module sdh_card_model (
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  // Answer speed and forced failure.
  input  wire logic        slow,
  input  wire logic        fail
);
  logic [31:0] sdcr, cmdr, blkr, ier, dma, breq, rd;
  logic [15:0] rem;
  logic [1:0]  wt;
  logic        take;
  logic        wcmd;
  assign take = psel && penable && pready;
  assign wcmd = take && pwrite && paddr == sdh_pkg::DEV_CMDR;
  // Data not being answered is inverted so a stale value never looks valid.
  assign prdata = pready ? rd : ~rd;
  always_comb
  begin
    case (paddr)
      sdh_pkg::DEV_SR:  rd = {4'h0, rem == 16'h0, 1'b0, rem == 16'h0, 1'b0, {8{fail}}, 3'h1,
                            11'h0, rem != 16'h0, 1'b1};
      sdh_pkg::DEV_RDR: rd = {16'h5a00, rem};
      default:          rd = 32'h0;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      {pready, wt, rem} <= '0;
      {sdcr, cmdr, blkr, ier, dma, breq} <= '0;
    end
    else
    begin
      pready <= psel && penable && !pready && wt == (slow ? 2'h2 : 2'h0);
      wt     <= (psel && penable && !pready) ? wt + 2'h1 : 2'h0;
      if (take && pwrite && paddr == sdh_pkg::DEV_SDCR)
        sdcr <= pwdata;
      if (take && pwrite && paddr == sdh_pkg::DEV_BLKR)
        blkr <= pwdata;
      if (take && pwrite && paddr == sdh_pkg::DEV_IER)
        ier <= pwdata;
      if (take && pwrite && paddr == sdh_pkg::DEV_DMA)
        dma <= pwdata;
      if (wcmd)
        cmdr <= pwdata;
      if (wcmd && pwdata[10:8] == sdh_pkg::SPC_BOOT_REQUEST_CODE)
      begin
        breq <= pwdata;
        rem  <= dma[8] ? 16'h0 : blkr[15:0];
      end
      if (take && !pwrite && paddr == sdh_pkg::DEV_RDR && rem != 16'h0)
        rem <= rem - 16'h1;
    end
  end
endmodule : sdh_card_model

// *** sim/tb.sv ***
// Self-checking bench for the card controller.
`timescale 1ns/1ps
module tb;
  logic        pclk = 1'b0, presetn = 1'b0, s_psel = 1'b0, s_penable = 1'b0, s_pwrite = 1'b0;
  logic        slow = 1'b0, fail = 1'b0, e, s_pready, s_pslverr, m_psel, m_penable, m_pwrite, m_pready;
  logic [7:0]  s_paddr = 8'h0;
  logic [31:0] s_pwdata = 32'h0, s_prdata, m_paddr, m_pwdata, m_prdata, q;
  int          miscompares = 0, check_count = 0, cycles = 0;
  localparam logic [31:0] LIM_CFG [5] = '{32'h400, 32'h400, 32'h410, 32'h410, 32'h400};
  localparam logic [31:0] LIM_BLK [5] = '{32'h200, 32'h201, 32'h1ff, 32'h200, 32'h0};
  localparam logic [31:0] LIM_PAR [5] = '{32'h0, 32'h8, 32'h0, 32'h8, 32'h8};
  sdh_ctrl DUT (.pclk(pclk), .presetn(presetn), .s_psel(s_psel), .s_penable(s_penable),
    .s_pwrite(s_pwrite), .s_paddr(s_paddr), .s_pwdata(s_pwdata), .s_pready(s_pready),
    .s_prdata(s_prdata), .s_pslverr(s_pslverr), .m_psel(m_psel), .m_penable(m_penable),
    .m_pwrite(m_pwrite), .m_paddr(m_paddr), .m_pwdata(m_pwdata), .m_pready(m_pready),
    .m_prdata(m_prdata));
  sdh_card_model mdl (.pclk(pclk), .presetn(presetn), .psel(m_psel), .penable(m_penable),
    .pwrite(m_pwrite), .paddr(m_paddr), .pwdata(m_pwdata), .pready(m_pready),
    .prdata(m_prdata), .slow(slow), .fail(fail));
  always #5 pclk = ~pclk;
  // ****
  // Tasks.
  // ****
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : close_out
  // Holds the request until the edge that samples ready, then releases it.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic f);
    @(posedge pclk);
    s_psel   <= 1'b1;
    s_pwrite <= w;
    s_paddr  <= a;
    s_pwdata <= d;
    @(posedge pclk);
    s_penable <= 1'b1;
    do @(posedge pclk); while (s_pready !== 1'b1);
    r = s_prdata;
    f = s_pslverr;
    s_psel    <= 1'b0;
    s_penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] v;
    logic        f;
    apb(1'b1, a, d, v, f);
  endtask : wr
  task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
    logic [31:0] v;
    logic        f;
    apb(1'b0, a, 32'h0, v, f);
    check(v & m, x);
  endtask : rdchk
  task automatic run(input logic [31:0] c, input logic [31:0] b, input logic [31:0] k, input logic [2:0] o);
    logic [31:0] v;
    logic        f;
    wr(sdh_pkg::OWN_STAT, 32'h1e);
    wr(sdh_pkg::OWN_CFG, c);
    wr(sdh_pkg::OWN_BLK, b);
    wr(sdh_pkg::OWN_ARG, 32'h1234);
    wr(sdh_pkg::OWN_CMD, k);
    wr(sdh_pkg::OWN_CTRL, {28'h0, o, 1'b1});
    v = 32'h1;
    while (v[sdh_pkg::ST_BUSY] !== 1'b0)
      apb(1'b0, sdh_pkg::OWN_STAT, 32'h0, v, f);
  endtask : run
  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      miscompares++;
      close_out();
    end
  end
  // ****
  // Scenarios.
  // ****
  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(sdh_pkg::OWN_STAT, 32'hffff_ffff, 32'h0);
    apb(1'b0, 8'h40, 32'h0, q, e);
    check({31'h0, e}, 32'h1);
    check(q, 32'h0);
    slow <= 1'b1;
    run(32'h9, 32'h1, 32'h5, sdh_pkg::OP_CMD);
    check(mdl.sdcr, 32'h1);
    check(mdl.cmdr, 32'h5);
    slow <= 1'b0;
    run(32'h4051a, 32'h0040_01ff, 32'h0005_0035, sdh_pkg::OP_SDIO);
    check(mdl.sdcr, 32'h82);
    check(mdl.blkr, 32'h0040_01ff);
    check(mdl.cmdr, 32'h010d_0035);
    check(mdl.ier & 32'he00, 32'h400);
    rdchk(sdh_pkg::OWN_STAT, 32'hf, 32'h2);
    for (int i = 0; i < 5; i++)
    begin
      run(LIM_CFG[i], LIM_BLK[i], 32'h0001_0035, sdh_pkg::OP_SDIO);
      rdchk(sdh_pkg::OWN_STAT, 32'h8, LIM_PAR[i]);
    end
    run(32'h400, 32'h1, 32'h0, sdh_pkg::OP_ABORT);
    check(mdl.cmdr & 32'h700, 32'h300);
    run(32'h2400, 32'h1, 32'h3c, sdh_pkg::OP_CMD);
    check(mdl.cmdr, 32'h3c);
    check(mdl.ier & 32'h2000, 32'h2000);
    run(32'h2400, 32'h1, 32'h0001_003d, sdh_pkg::OP_CMD);
    check(mdl.cmdr, 32'h0001_003d);
    rdchk(sdh_pkg::OWN_STAT, 32'h4, 32'h0);
    run(32'h1404, 32'h3, 32'h0, sdh_pkg::OP_BOOT);
    check(mdl.sdcr, 32'h40);
    check(mdl.blkr, 32'h0200_0003);
    check(mdl.breq & 32'h080f_0700, 32'h0805_0600);
    check(mdl.cmdr & 32'h700, 32'h700);
    rdchk(sdh_pkg::OWN_WCNT, 32'hffff_ffff, 32'h3);
    rdchk(sdh_pkg::OWN_DATA, 32'hffff_ffff, 32'h5a00_0001);
    run(32'h1c04, 32'h2, 32'h0, sdh_pkg::OP_BOOT);
    check(mdl.dma, 32'h100);
    check(mdl.cmdr & 32'h700, 32'h700);
    slow <= 1'b1;
    run(32'h6400, 32'h0, 32'h0, sdh_pkg::OP_RECOVER);
    check(mdl.cmdr & 32'h3f, 32'h27);
    rdchk(sdh_pkg::OWN_STAT, 32'h14, 32'h0);
    fail <= 1'b1;
    run(32'h6400, 32'h0, 32'h0, sdh_pkg::OP_RECOVER);
    check(mdl.cmdr & 32'h3f, 32'h0);
    rdchk(sdh_pkg::OWN_STAT, 32'h14, 32'h04);
    close_out();
  end
endmodule : tb
